// file: verilog/sfp_ctrl.sv
// Operation
// - four pairs each hold a deflection threshold 0..127 and a velocity.
// - velocity of the highest-numbered pair whose threshold is reached is commanded, no interpolation.
// - slider at centre gives zero velocity.
// - the same pairs serve both deflection directions.
// - output includes proportional gain 0..32767 times position error.
// - output includes integral gain 0..32767 times accumulated error.
// - output includes derivative gain 0..32767 times error change.
// - accumulated error is clamped to a limit 0..32767.
// - with limit option on, activity indicator flashes at either limit.
// - with identify option on, power indicator flashes on identify request.
// - with motion option on, activity indicator lit while motor moves, except while it flashes at a limit.
// - each indicator option has its own enable.
// - relative-jog mode: a press jogs by stored step in button direction.
// - absolute-preset mode: each button moves to its stored position.
// - stored presets are used only in absolute-preset mode.
// - both buttons held 2 s start a home move in any mode.
// - four bar velocities; a bar request applies the selected one.
// - each limit input is read by its configured contact sense.
// - a limit configured absent is disregarded.
`include "sfp_map.svh"
`timescale 1ns/1ns
`default_nettype none
module sfp_ctrl
   import sfp_pkg::*;
#(
   parameter int HOME_HOLD_CYC = `SFP_HOME_HOLD_MS * `SFP_CLK_KHZ,
   parameter int FLASH_CYC     = `SFP_FLASH_MS * `SFP_CLK_KHZ
) (
   // clock and reset
   input  wire logic               clk_sys_in,
   input  wire logic               rst_in,
   // register port
   input  wire logic [7:0]         addr_in,
   input  wire logic [31:0]        wdata_in,
   input  wire logic               wr_in,
   input  wire logic               rd_in,
   output var  logic [31:0]        rdata_out,
   // front panel
   input  wire logic signed [7:0]  slider_defl_in,
   input  wire logic               btn_top_in,
   input  wire logic               btn_bot_in,
   // motor side
   input  wire logic               lim_fwd_in,
   input  wire logic               lim_rev_in,
   input  wire logic               moving_in,
   input  wire logic               loop_tick_in,
   input  wire logic signed [15:0] pos_err_in,
   // slider velocity command
   output var  logic [15:0]        slider_vel_out,
   output var  logic               slider_dir_out,
   output var  logic [2:0]         slider_step_out,
   // move request
   output var  logic               mv_req_out,
   output var  logic [1:0]         mv_kind_out,
   output var  logic               mv_dir_out,
   output var  logic [31:0]        mv_pos_out,
   output var  logic [15:0]        mv_vel_out,
   // servo loop drive
   output var  logic signed [34:0] servo_out,
   // indicators and limit states
   output var  logic               act_led_out,
   output var  logic               pwr_led_out,
   output var  logic               lim_fwd_act_out,
   output var  logic               lim_rev_act_out
);

   sfp_state_t st_r;
   sfp_state_t st_nxt;

   // limit input read through its contact sense
   function automatic logic lim_active(input logic [1:0] sense, input logic pin);
      lim_active = 1'b0;
      if (sense == SFP_LS_MAKES) begin
         lim_active = pin;
      end else if (sense == SFP_LS_BREAKS) begin
         lim_active = ~pin;
      end
   endfunction

   // gain times signed operand
   function automatic logic signed [32:0] gain_mul(input logic [14:0] g, input logic signed [16:0] v);
      gain_mul = $signed({1'b0, g}) * v;
   endfunction

   logic [6:0]         mag;
   logic signed [16:0] err_sum;
   logic signed [16:0] ilim_s;
   logic signed [15:0] integ_new;
   logic [1:0]         btn;
   logic [1:0]         press;
   logic               blink_tick;
   logic [1:0]         bar_idx;

   // next-state logic
   always_comb begin
      st_nxt     = st_r;
      st_nxt.rdata  = 32'h0;
      st_nxt.mv_req = 1'b0;
      btn        = {btn_top_in, btn_bot_in};
      press      = btn & ~st_r.btn_prev;
      bar_idx    = wdata_in[1:0];
      // register writes
      if (wr_in) begin
         unique case (addr_in)
            `SFP_OFS_CTRL:     st_nxt.ctrl = wdata_in[7:0];
            `SFP_OFS_KP:       st_nxt.kp = wdata_in[14:0];
            `SFP_OFS_KI:       st_nxt.ki = wdata_in[14:0];
            `SFP_OFS_KD:       st_nxt.kd = wdata_in[14:0];
            `SFP_OFS_ILIM:     st_nxt.ilim = wdata_in[14:0];
            `SFP_OFS_JOG_STEP: st_nxt.jog_step = wdata_in;
            `SFP_OFS_JOG_VEL:  st_nxt.jog_vel = wdata_in[15:0];
            `SFP_OFS_POS_TOP:  st_nxt.pos_top = wdata_in;
            `SFP_OFS_POS_BOT:  st_nxt.pos_bot = wdata_in;
            default: begin
               for (int i = 0; i < 4; i++) begin
                  if (addr_in == `SFP_OFS_POT0 + 8'(4 * i)) begin
                     st_nxt.pot_thr[i] = wdata_in[6:0];
                     st_nxt.pot_vel[i] = wdata_in[`SFP_POT_VEL_LSB +: 16];
                  end
                  if (addr_in == `SFP_OFS_BAR0 + 8'(4 * i)) begin
                     st_nxt.bar_vel[i] = wdata_in[15:0];
                  end
               end
            end
         endcase
      end
      // register reads, data valid the following cycle only
      if (rd_in) begin
         unique case (addr_in)
            `SFP_OFS_CTRL:     st_nxt.rdata = {24'h0, st_r.ctrl};
            `SFP_OFS_KP:       st_nxt.rdata = {17'h0, st_r.kp};
            `SFP_OFS_KI:       st_nxt.rdata = {17'h0, st_r.ki};
            `SFP_OFS_KD:       st_nxt.rdata = {17'h0, st_r.kd};
            `SFP_OFS_ILIM:     st_nxt.rdata = {17'h0, st_r.ilim};
            `SFP_OFS_JOG_STEP: st_nxt.rdata = st_r.jog_step;
            `SFP_OFS_JOG_VEL:  st_nxt.rdata = {16'h0, st_r.jog_vel};
            `SFP_OFS_POS_TOP:  st_nxt.rdata = st_r.pos_top;
            `SFP_OFS_POS_BOT:  st_nxt.rdata = st_r.pos_bot;
            `SFP_OFS_STATUS:   st_nxt.rdata = {22'h0, st_r.slider_dir, st_r.slider_step, st_r.pwr_led,
                                               st_r.act_led, moving_in, st_r.home_done, st_r.lim_r, st_r.lim_f};
            default: begin
               for (int i = 0; i < 4; i++) begin
                  if (addr_in == `SFP_OFS_POT0 + 8'(4 * i)) begin
                     st_nxt.rdata = {st_r.pot_vel[i], 9'h0, st_r.pot_thr[i]};
                  end
                  if (addr_in == `SFP_OFS_BAR0 + 8'(4 * i)) begin
                     st_nxt.rdata = {16'h0, st_r.bar_vel[i]};
                  end
               end
            end
         endcase
      end
      // slider quantiser: sign gives direction, magnitude picks step
      mag = slider_defl_in[7] ? ((slider_defl_in == -8'sd128) ? 7'h7F : 7'((-slider_defl_in)))
                              : slider_defl_in[6:0];
      st_nxt.slider_dir  = ~slider_defl_in[7];
      st_nxt.slider_step = 3'h0;
      st_nxt.slider_vel  = 16'h0;
      if (mag != 7'h0) begin
         for (int i = 0; i < 4; i++) begin
            if (mag >= st_r.pot_thr[i]) begin
               st_nxt.slider_step = 3'(i + 1);
               st_nxt.slider_vel  = st_r.pot_vel[i];
            end
         end
      end
      // servo loop terms
      err_sum   = 17'(st_r.integ) + 17'(pos_err_in);
      ilim_s    = $signed({2'h0, st_r.ilim});
      integ_new = (err_sum > ilim_s) ? 16'(ilim_s) : (err_sum < -ilim_s) ? 16'(-ilim_s) : 16'(err_sum);
      if (loop_tick_in) begin
         st_nxt.integ    = integ_new;
         st_nxt.err_prev = pos_err_in;
         st_nxt.servo    = 35'(gain_mul(st_r.kp, 17'(pos_err_in)))
                         + 35'(gain_mul(st_r.ki, 17'(integ_new)))
                         + 35'(gain_mul(st_r.kd, 17'(pos_err_in) - 17'(st_r.err_prev)));
      end
      // buttons and drive bar requests
      st_nxt.btn_prev = btn;
      if (btn == 2'b11) begin
         if (!st_r.home_done) begin
            if (st_r.hold_cnt == 26'(HOME_HOLD_CYC - 1)) begin
               st_nxt.mv_req    = 1'b1;
               st_nxt.mv_kind   = SFP_MV_HOME;
               st_nxt.home_done = 1'b1;
               st_nxt.hold_cnt  = 26'h0;
            end else begin
               st_nxt.hold_cnt = st_r.hold_cnt + 26'h1;
            end
         end
      end else begin
         st_nxt.hold_cnt  = 26'h0;
         st_nxt.home_done = 1'b0;
         if (press != 2'b00 && btn != 2'b11) begin
            st_nxt.mv_req = 1'b1;
            st_nxt.mv_dir = press[1];
            if (st_r.ctrl[`SFP_CTRL_ABS]) begin
               st_nxt.mv_kind = SFP_MV_ABS;
               st_nxt.mv_pos  = press[1] ? st_r.pos_top : st_r.pos_bot;
               st_nxt.mv_vel  = st_r.jog_vel;
            end else begin
               st_nxt.mv_kind = SFP_MV_JOG;
               st_nxt.mv_pos  = st_r.jog_step;
               st_nxt.mv_vel  = st_r.jog_vel;
            end
         end else if (wr_in && addr_in == `SFP_OFS_BAR_REQ) begin
            st_nxt.mv_req  = 1'b1;
            st_nxt.mv_kind = SFP_MV_BAR;
            st_nxt.mv_dir  = wdata_in[`SFP_BAR_DIR];
            st_nxt.mv_vel  = st_r.bar_vel[bar_idx];
         end
      end
      // limits
      st_nxt.lim_f = lim_active(st_r.ctrl[`SFP_CTRL_FSENSE +: 2], lim_fwd_in);
      st_nxt.lim_r = lim_active(st_r.ctrl[`SFP_CTRL_RSENSE +: 2], lim_rev_in);
      // flash timebase
      blink_tick = (st_r.blink_cnt == 23'(FLASH_CYC - 1));
      st_nxt.blink_cnt = blink_tick ? 23'h0 : st_r.blink_cnt + 23'h1;
      if (blink_tick) begin
         st_nxt.blink = ~st_r.blink;
      end
      // activity indicator
      if (st_r.ctrl[`SFP_CTRL_LIM_EN] && (st_r.lim_f || st_r.lim_r)) begin
         st_nxt.act_led = st_r.blink;
      end else begin
         st_nxt.act_led = st_r.ctrl[`SFP_CTRL_MOVE_EN] & moving_in;
      end
      // power indicator, identify request wins over countdown
      if (wr_in && addr_in == `SFP_OFS_IDENT && wdata_in[0] && st_r.ctrl[`SFP_CTRL_IDENT_EN]) begin
         st_nxt.ident_cnt = `SFP_IDENT_TOGGLES;
      end else if (blink_tick && st_r.ident_cnt != 4'h0) begin
         st_nxt.ident_cnt = st_r.ident_cnt - 4'h1;
         st_nxt.pwr_led   = ~st_r.pwr_led;
      end else if (st_r.ident_cnt == 4'h0) begin
         st_nxt.pwr_led = 1'b1;
      end
   end

   // state register
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         st_r         <= '0;
         st_r.ctrl    <= `SFP_CTRL_RST;
         st_r.pwr_led <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from the state register
   assign rdata_out       = st_r.rdata;
   assign slider_vel_out  = st_r.slider_vel;
   assign slider_dir_out  = st_r.slider_dir;
   assign slider_step_out = st_r.slider_step;
   assign mv_req_out      = st_r.mv_req;
   assign mv_kind_out     = st_r.mv_kind;
   assign mv_dir_out      = st_r.mv_dir;
   assign mv_pos_out      = st_r.mv_pos;
   assign mv_vel_out      = st_r.mv_vel;
   assign servo_out       = st_r.servo;
   assign act_led_out     = st_r.act_led;
   assign pwr_led_out     = st_r.pwr_led;
   assign lim_fwd_act_out = st_r.lim_f;
   assign lim_rev_act_out = st_r.lim_r;

   // checks
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   property p_centre;
      slider_defl_in == 8'sh0 |=> slider_vel_out == 16'h0 && slider_step_out == 3'h0;
   endproperty
   a_centre: assert property (p_centre) else $error("slider centre not stationary");

   property p_top_step;
      slider_defl_in == 8'sh7F && st_r.pot_thr[3] != 7'h0 && !wr_in
         |=> slider_step_out == 3'h4 && slider_vel_out == $past(st_r.pot_vel[3]) && slider_dir_out;
   endproperty
   a_top_step: assert property (p_top_step) else $error("full deflection not top step");

   property p_integ;
      loop_tick_in |=> st_r.integ <= $signed({2'h0, $past(st_r.ilim)})
                    && st_r.integ >= -$signed({2'h0, $past(st_r.ilim)});
   endproperty
   a_integ: assert property (p_integ) else $error("integral exceeds limit");

   property p_prop;
      loop_tick_in && st_r.ki == 15'h0 && st_r.kd == 15'h0 && !wr_in
         |=> servo_out == 35'($signed({1'b0, $past(st_r.kp)}) * $past(pos_err_in));
   endproperty
   a_prop: assert property (p_prop) else $error("proportional term wrong");

   property p_home;
      btn_top_in && btn_bot_in && !st_r.home_done && st_r.hold_cnt == 26'(HOME_HOLD_CYC - 1)
         |=> mv_req_out && mv_kind_out == SFP_MV_HOME;
   endproperty
   a_home: assert property (p_home) else $error("home move not started");

   property p_jog;
      !st_r.ctrl[`SFP_CTRL_ABS] && btn_top_in && !btn_bot_in && !st_r.btn_prev[1]
         |=> mv_req_out && mv_kind_out == SFP_MV_JOG && mv_dir_out;
   endproperty
   a_jog: assert property (p_jog) else $error("jog press not honoured");

   property p_abs;
      st_r.ctrl[`SFP_CTRL_ABS] && btn_bot_in && !btn_top_in && !st_r.btn_prev[0] && !wr_in
         |=> mv_req_out && mv_kind_out == SFP_MV_ABS && mv_pos_out == $past(st_r.pos_bot);
   endproperty
   a_abs: assert property (p_abs) else $error("preset move wrong");

   property p_lim_absent;
      st_r.ctrl[`SFP_CTRL_FSENSE +: 2] == SFP_LS_ABSENT |=> !lim_fwd_act_out;
   endproperty
   a_lim_absent: assert property (p_lim_absent) else $error("absent limit reported");

   property p_lim_breaks;
      st_r.ctrl[`SFP_CTRL_FSENSE +: 2] == SFP_LS_BREAKS |=> lim_fwd_act_out == !$past(lim_fwd_in);
   endproperty
   a_lim_breaks: assert property (p_lim_breaks) else $error("opening limit not sensed");

   property p_rev_full;
      slider_defl_in == 8'sh80 && st_r.pot_thr[3] != 7'h0 && !wr_in
         |=> slider_step_out == 3'h4 && !slider_dir_out;
   endproperty
   a_rev_full: assert property (p_rev_full) else $error("full reverse deflection not top step");

   property p_move_led;
      st_r.ctrl[`SFP_CTRL_MOVE_EN] && moving_in && !st_r.lim_f && !st_r.lim_r |=> act_led_out;
   endproperty
   a_move_led: assert property (p_move_led) else $error("moving indicator off");

   property p_rd_idle;
      !rd_in |=> rdata_out == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

   c_home: cover property (mv_req_out && mv_kind_out == SFP_MV_HOME);
   c_bar: cover property (mv_req_out && mv_kind_out == SFP_MV_BAR);
   c_ident: cover property (st_r.ident_cnt != 4'h0 && !pwr_led_out);
   c_abs: cover property (mv_req_out && mv_kind_out == SFP_MV_ABS);
endmodule
`default_nettype wire

// file: verilog/sfp_map.svh
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH
// register byte offsets
`define SFP_OFS_CTRL     8'h00
`define SFP_OFS_IDENT    8'h04
`define SFP_OFS_POT0     8'h08
`define SFP_OFS_BAR0     8'h18
`define SFP_OFS_KP       8'h28
`define SFP_OFS_KI       8'h2C
`define SFP_OFS_KD       8'h30
`define SFP_OFS_ILIM     8'h34
`define SFP_OFS_JOG_STEP 8'h38
`define SFP_OFS_JOG_VEL  8'h3C
`define SFP_OFS_POS_TOP  8'h40
`define SFP_OFS_POS_BOT  8'h44
`define SFP_OFS_BAR_REQ  8'h48
`define SFP_OFS_STATUS   8'h4C
// control register fields
`define SFP_CTRL_ABS      0
`define SFP_CTRL_LIM_EN   1
`define SFP_CTRL_IDENT_EN 2
`define SFP_CTRL_MOVE_EN  3
`define SFP_CTRL_FSENSE   4
`define SFP_CTRL_RSENSE   6
`define SFP_CTRL_RST      8'h0E
// pot pair fields: threshold low, velocity high
`define SFP_POT_VEL_LSB   16
// bar request fields
`define SFP_BAR_DIR       2
// timing
`define SFP_CLK_KHZ       25000
`define SFP_HOME_HOLD_MS  2000
`define SFP_FLASH_MS      250
`define SFP_IDENT_TOGGLES 4'h6
`endif

// file: verilog/sfp_pkg.sv
package sfp_pkg;
   // kind of move handed to the profile generator
   typedef enum logic [1:0] {
      SFP_MV_JOG  = 2'h0,
      SFP_MV_ABS  = 2'h1,
      SFP_MV_HOME = 2'h2,
      SFP_MV_BAR  = 2'h3
   } sfp_move_t;
   // limit switch contact sense
   typedef enum logic [1:0] {
      SFP_LS_ABSENT = 2'h0,
      SFP_LS_MAKES  = 2'h1,
      SFP_LS_BREAKS = 2'h2,
      SFP_LS_IGNORE = 2'h3
   } sfp_sense_t;
   // whole state of the control block
   typedef struct packed {
      logic [7:0]        ctrl;
      logic [3:0][6:0]   pot_thr;
      logic [3:0][15:0]  pot_vel;
      logic [3:0][15:0]  bar_vel;
      logic [14:0]       kp;
      logic [14:0]       ki;
      logic [14:0]       kd;
      logic [14:0]       ilim;
      logic [31:0]       jog_step;
      logic [15:0]       jog_vel;
      logic [31:0]       pos_top;
      logic [31:0]       pos_bot;
      logic [31:0]       rdata;
      logic signed [15:0] integ;
      logic signed [15:0] err_prev;
      logic signed [34:0] servo;
      logic [15:0]       slider_vel;
      logic              slider_dir;
      logic [2:0]        slider_step;
      logic              mv_req;
      sfp_move_t         mv_kind;
      logic              mv_dir;
      logic [31:0]       mv_pos;
      logic [15:0]       mv_vel;
      logic [1:0]        btn_prev;
      logic [25:0]       hold_cnt;
      logic              home_done;
      logic [22:0]       blink_cnt;
      logic              blink;
      logic [3:0]        ident_cnt;
      logic              act_led;
      logic              pwr_led;
      logic              lim_f;
      logic              lim_r;
   } sfp_state_t;
endpackage

// file: dv/sfp_motor_model.sv
`timescale 1ns/1ns
`default_nettype none
// brushed motor with encoder and two limit switches, one count per cycle
module sfp_motor_model
   import sfp_pkg::*;
#(
   parameter int LIM_HI = 60,
   parameter int LIM_LO = -60,
   parameter int TICK   = 8
) (
   // clock and reset
   input  wire logic          clk_sys_in,
   input  wire logic          rst_in,
   // move request from the panel logic
   input  wire logic          mv_req_in,
   input  wire logic [1:0]    mv_kind_in,
   input  wire logic          mv_dir_in,
   input  wire logic [31:0]   mv_pos_in,
   // switches, motion and servo sampling
   output var  logic          lim_fwd_out,
   output var  logic          lim_rev_out,
   output var  logic          moving_out,
   output var  logic          loop_tick_out,
   output var  logic signed [15:0] pos_err_out
);
   int pos;
   int tgt;
   int tc;
   int d;
   // travel toward the target, stopping hard on a switch
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         pos = 0;
         tgt = 0;
         tc = 0;
         moving_out <= 1'b0;
         loop_tick_out <= 1'b0;
         lim_fwd_out <= 1'b0;
         lim_rev_out <= 1'b0;
         pos_err_out <= 16'h0;
      end else begin
         loop_tick_out <= (tc == TICK - 1);
         tc = (tc == TICK - 1) ? 0 : tc + 1;
         d = (tgt > pos && pos < LIM_HI) ? 1 : (tgt < pos && pos > LIM_LO) ? -1 : 0;
         pos = pos + d;
         moving_out <= (d != 0);
         if (mv_req_in) begin
            case (sfp_move_t'(mv_kind_in))
               SFP_MV_JOG: tgt = mv_dir_in ? pos + int'(mv_pos_in) : pos - int'(mv_pos_in);
               SFP_MV_ABS: tgt = int'(mv_pos_in);
               SFP_MV_BAR: tgt = mv_dir_in ? LIM_HI + 10 : LIM_LO - 10;
               default:    tgt = LIM_LO - 10;
            endcase
         end
         // switches close on contact; registered so the panel samples settled values
         lim_fwd_out <= (pos >= LIM_HI);
         lim_rev_out <= (pos <= LIM_LO);
         pos_err_out <= 16'(tgt - pos);
      end
   end
endmodule
`default_nettype wire

// file: dv/sfp_ctrl_tb.sv
`include "sfp_map.svh"
`timescale 1ns/1ns
`default_nettype none
module sfp_ctrl_tb import sfp_pkg::*;;
   localparam int HOLD  = 20;
   localparam int FLASH = 4;
   typedef struct {logic [7:0] d; logic [2:0] s; logic [15:0] v; logic dr;} sfp_row_t;
   typedef struct {logic [7:0] a; logic [31:0] r;} sfp_reg_t;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] addr_in = 8'h00;
   logic [31:0] wdata_in = 32'h0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic signed [7:0] slider_defl_in = 8'h00;
   logic btn_top_in = 1'b0;
   logic btn_bot_in = 1'b0;
   logic lim_fwd_in, lim_rev_in, moving_in, loop_tick_in;
   logic signed [15:0] pos_err_in;
   logic [31:0] rdata_out, mv_pos_out, rv;
   logic [15:0] slider_vel_out, mv_vel_out;
   logic [2:0] slider_step_out;
   logic [1:0] mv_kind_out;
   logic slider_dir_out, mv_req_out, mv_dir_out, act_led_out, pwr_led_out;
   logic lim_fwd_act_out, lim_rev_act_out, act_q, pwr_q;
   logic signed [34:0] servo_out;
   int num_errors = 0;
   int num_checks = 0;
   int i, cnt, achg, pchg;
   longint gi [4] = '{0, 0, 0, 0};
   longint ig, ep, sx;
   logic [6:0] thr [4] = '{7'h14, 7'h32, 7'h50, 7'h64};
   logic [15:0] vel [4] = '{16'h0005, 16'h000A, 16'h0014, 16'h0014};
   logic [15:0] bar [4] = '{16'h0011, 16'h0022, 16'h0033, 16'h0033};
   sfp_row_t rows [11] = '{'{8'h00, 3'h0, 16'h0000, 1'b0}, '{8'h13, 3'h0, 16'h0000, 1'b0},
      '{8'h14, 3'h1, 16'h0005, 1'b1}, '{8'hEC, 3'h1, 16'h0005, 1'b0}, '{8'h32, 3'h2, 16'h000A, 1'b1},
      '{8'hB1, 3'h2, 16'h000A, 1'b0}, '{8'h50, 3'h3, 16'h0014, 1'b1}, '{8'h64, 3'h4, 16'h0014, 1'b1},
      '{8'h7F, 3'h4, 16'h0014, 1'b1}, '{8'h80, 3'h4, 16'h0014, 1'b0}, '{8'h9C, 3'h4, 16'h0014, 1'b0}};
   sfp_reg_t regs [7] = '{'{`SFP_OFS_KP, 32'h00007FFF}, '{`SFP_OFS_KI, 32'h00007FFF},
      '{`SFP_OFS_KD, 32'h00007FFF}, '{`SFP_OFS_ILIM, 32'h00007FFF}, '{`SFP_OFS_POT0, 32'hFFFF007F},
      '{`SFP_OFS_BAR0, 32'h0000FFFF}, '{8'h50, 32'h00000000}};

   // clock
   always #20 clk_sys_in = ~clk_sys_in;

   sfp_ctrl #(.HOME_HOLD_CYC(HOLD), .FLASH_CYC(FLASH)) dut_u (.clk_sys_in, .rst_in, .addr_in, .wdata_in,
      .wr_in, .rd_in, .rdata_out, .slider_defl_in, .btn_top_in, .btn_bot_in, .lim_fwd_in, .lim_rev_in,
      .moving_in, .loop_tick_in, .pos_err_in, .slider_vel_out, .slider_dir_out, .slider_step_out,
      .mv_req_out, .mv_kind_out, .mv_dir_out, .mv_pos_out, .mv_vel_out, .servo_out, .act_led_out,
      .pwr_led_out, .lim_fwd_act_out, .lim_rev_act_out);

   sfp_motor_model motor_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .mv_req_in(mv_req_out),
      .mv_kind_in(mv_kind_out), .mv_dir_in(mv_dir_out), .mv_pos_in(mv_pos_out), .lim_fwd_out(lim_fwd_in),
      .lim_rev_out(lim_rev_in), .moving_out(moving_in), .loop_tick_out(loop_tick_in), .pos_err_out(pos_err_in));

   task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("FAIL %s expected %0h seen %0h", n, e, s);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk_sys_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      @(negedge clk_sys_in);
      rv = rdata_out;
   endtask

   task automatic wait_mv(input logic [1:0] k, input logic dr, input logic [31:0] p, input logic [15:0] v);
      int n;
      n = 0;
      @(negedge clk_sys_in);
      while (mv_req_out !== 1'b1 && n < 60) begin
         @(negedge clk_sys_in);
         n++;
      end
      chk("mv_req", mv_req_out, 1'b1);
      chk("mv_kind", mv_kind_out, k);
      chk("mv_dir", mv_dir_out, dr);
      if (k < 2'h2) chk("mv_pos", mv_pos_out, p);
      chk("mv_vel", mv_vel_out, v);
   endtask

   task automatic press(input logic t, input logic b, input logic [1:0] k, input logic [31:0] p);
      @(posedge clk_sys_in);
      btn_top_in <= t;
      btn_bot_in <= b;
      wait_mv(k, t, p, 16'h0007);
      @(posedge clk_sys_in);
      btn_top_in <= 1'b0;
      btn_bot_in <= 1'b0;
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // count indicator changes
   always @(negedge clk_sys_in) begin
      if (act_led_out !== act_q) achg++;
      if (pwr_led_out !== pwr_q) pchg++;
      act_q = act_led_out;
      pwr_q = pwr_led_out;
   end

   // servo reference: check the last result, then fold in the new sample
   always @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         ig = 0;
         ep = 0;
         sx = 0;
      end else if (loop_tick_in === 1'b1) begin
         chk("servo", servo_out, sx);
         ig = ig + pos_err_in;
         ig = (ig > gi[3]) ? gi[3] : (ig < -gi[3]) ? -gi[3] : ig;
         sx = gi[0] * pos_err_in + gi[1] * ig + gi[2] * (pos_err_in - ep);
         ep = pos_err_in;
      end
   end

   // watchdog
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      num_errors++;
      give_verdict();
   end

   initial begin
      repeat (20) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      @(negedge clk_sys_in);
      chk("pwr_led", pwr_led_out, 1'b1);
      chk("slider_step", slider_step_out, 3'h0);
      rd_reg(`SFP_OFS_CTRL);
      chk("ctrl", rv, 32'h0000000E);
      for (i = 0; i < 7; i++) begin
         wr_reg(regs[i].a, 32'hFFFFFFFF);
         rd_reg(regs[i].a);
         chk("reg", rv, regs[i].r);
      end
      // strictly rising thresholds, the top two speeds repeated
      for (i = 0; i < 4; i++) begin
         wr_reg(`SFP_OFS_POT0 + 8'(4 * i), {vel[i], 9'h000, thr[i]});
         wr_reg(`SFP_OFS_BAR0 + 8'(4 * i), {16'h0000, bar[i]});
      end
      wr_reg(`SFP_OFS_KP, 32'h3);
      wr_reg(`SFP_OFS_KI, 32'h2);
      wr_reg(`SFP_OFS_KD, 32'h5);
      wr_reg(`SFP_OFS_ILIM, 32'hA);
      gi = '{3, 2, 5, 10};
      wr_reg(`SFP_OFS_JOG_STEP, 32'h14);
      wr_reg(`SFP_OFS_JOG_VEL, 32'h7);
      wr_reg(`SFP_OFS_POS_TOP, 32'h3E8);
      wr_reg(`SFP_OFS_POS_BOT, 32'h5);
      wr_reg(`SFP_OFS_CTRL, 32'h5E);
      for (i = 0; i < 11; i++) begin
         @(posedge clk_sys_in);
         slider_defl_in <= rows[i].d;
         repeat (2) @(posedge clk_sys_in);
         @(negedge clk_sys_in);
         chk("slider_step", slider_step_out, rows[i].s);
         chk("slider_vel", slider_vel_out, rows[i].v);
         if (rows[i].s != 3'h0) chk("slider_dir", slider_dir_out, rows[i].dr);
      end
      @(posedge clk_sys_in);
      slider_defl_in <= 8'h00;
      press(1'b1, 1'b0, SFP_MV_JOG, 32'h14);
      repeat (3) @(negedge clk_sys_in);
      chk("act_led", act_led_out, 1'b1);
      repeat (30) @(posedge clk_sys_in);
      press(1'b0, 1'b1, SFP_MV_JOG, 32'h14);
      repeat (30) @(posedge clk_sys_in);
      wr_reg(`SFP_OFS_CTRL, 32'h5F);
      press(1'b1, 1'b0, SFP_MV_ABS, 32'h3E8);
      repeat (80) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk("lim_fwd", lim_fwd_act_out, 1'b1);
      chk("lim_rev", lim_rev_act_out, 1'b0);
      achg = 0;
      repeat (40) @(posedge clk_sys_in);
      chk("act_flash", achg >= 4, 1'b1);
      wr_reg(`SFP_OFS_CTRL, 32'h5D);
      repeat (3) @(negedge clk_sys_in);
      chk("act_led", act_led_out, 1'b0);
      wr_reg(`SFP_OFS_CTRL, 32'h6F);
      repeat (3) @(negedge clk_sys_in);
      chk("lim_fwd", lim_fwd_act_out, 1'b0);
      press(1'b0, 1'b1, SFP_MV_ABS, 32'h5);
      repeat (80) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk("lim_fwd", lim_fwd_act_out, 1'b1);
      wr_reg(`SFP_OFS_CTRL, 32'h4F);
      repeat (3) @(negedge clk_sys_in);
      chk("lim_fwd", lim_fwd_act_out, 1'b0);
      wr_reg(`SFP_OFS_CTRL, 32'h5E);
      for (i = 0; i < 4; i++) begin
         wr_reg(`SFP_OFS_BAR_REQ, {29'h0, i[0], i[1:0]});
         wait_mv(SFP_MV_BAR, i[0], 32'h0, bar[i]);
      end
      @(posedge clk_sys_in);
      btn_top_in <= 1'b1;
      btn_bot_in <= 1'b1;
      cnt = 0;
      @(negedge clk_sys_in);
      while (mv_req_out !== 1'b1 && cnt < 60) begin
         @(negedge clk_sys_in);
         cnt++;
      end
      chk("home_delay", cnt >= HOLD && cnt <= HOLD + 3, 1'b1);
      chk("home_kind", mv_kind_out, SFP_MV_HOME);
      cnt = 0;
      repeat (30) begin
         @(negedge clk_sys_in);
         if (mv_req_out === 1'b1) cnt++;
      end
      chk("home_once", cnt, 0);
      @(posedge clk_sys_in);
      btn_top_in <= 1'b0;
      btn_bot_in <= 1'b0;
      pchg = 0;
      wr_reg(`SFP_OFS_IDENT, 32'h1);
      repeat (60) @(posedge clk_sys_in);
      chk("ident_toggles", pchg, 6);
      chk("pwr_led", pwr_led_out, 1'b1);
      wr_reg(`SFP_OFS_CTRL, 32'h5A);
      pchg = 0;
      wr_reg(`SFP_OFS_IDENT, 32'h1);
      repeat (60) @(posedge clk_sys_in);
      chk("ident_off", pchg, 0);
      // home move has parked the motor on the reverse switch
      chk("lim_rev", lim_rev_act_out, 1'b1);
      wr_reg(`SFP_OFS_CTRL, 32'hDA);
      repeat (3) @(negedge clk_sys_in);
      chk("lim_rev_ign", lim_rev_act_out, 1'b0);
      give_verdict();
   end
endmodule
`default_nettype wire
